// ===== logic/pemd_pkg.sv
// Constants, field layouts and types for the process-entry mode decoder.
// Assumes a 32-bit APB register bus and a single 50 MHz clock.
package pemd_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CAP = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENTRY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ADDR_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h1c;

  // ---------------------------------------------------------------
  // Entry low control fields
  // ---------------------------------------------------------------
  localparam int unsigned ENTRY_W = 12;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned EB_PRESENT = 0;
  localparam int unsigned EB_SUPPRESS = 1;
  localparam int unsigned EB_WSEL_LSB = 2;
  localparam int unsigned EB_SL_EXEC = 5;
  localparam int unsigned EB_TT_LSB = 6;
  localparam int unsigned EB_SL_AD = 9;
  localparam logic [FIELD_W-1:0] TT_RSVD = 3'h0;
  localparam logic [FIELD_W-1:0] TT_FIRST = 3'h1;
  localparam logic [FIELD_W-1:0] TT_SECOND = 3'h2;
  localparam logic [FIELD_W-1:0] TT_NESTED = 3'h3;
  localparam logic [FIELD_W-1:0] TT_PASS = 3'h4;
  localparam logic [FIELD_W-1:0] WSEL_NONE = 3'h0;
  localparam logic [FIELD_W-1:0] WSEL_39 = 3'h1;
  localparam logic [FIELD_W-1:0] WSEL_48 = 3'h2;
  localparam logic [FIELD_W-1:0] WSEL_57 = 3'h3;
  localparam int unsigned WID_W = 7;
  localparam logic [WID_W-1:0] WIDTH_39 = 7'h27;
  localparam logic [WID_W-1:0] WIDTH_48 = 7'h30;
  localparam logic [WID_W-1:0] WIDTH_57 = 7'h39;
  localparam logic [2:0] LEVELS_39 = 3'h3;
  localparam logic [2:0] LEVELS_48 = 3'h4;
  localparam logic [2:0] LEVELS_57 = 3'h5;

  // ---------------------------------------------------------------
  // Capability, command, status and result layouts
  // ---------------------------------------------------------------
  localparam int unsigned CAP_W = 11;
  localparam int unsigned CB_FIRST = 0;
  localparam int unsigned CB_SECOND = 1;
  localparam int unsigned CB_NESTED = 2;
  localparam int unsigned CB_PASS = 3;
  localparam int unsigned CB_SLAD = 4;
  localparam int unsigned CB_WMASK_LSB = 8;
  localparam logic [CAP_W-1:0] CAP_RST = 11'h71f;
  localparam int unsigned CMDB_GO = 0;
  localparam int unsigned CMDB_CTX = 1;
  localparam int unsigned EV_W = 3;
  localparam int unsigned SB_DONE = 0;
  localparam int unsigned SB_REPORT = 1;
  localparam int unsigned SB_SILENT = 2;
  localparam int unsigned RB_LEVELS_LSB = 12;
  localparam int unsigned RB_WIDTH_LSB = 16;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PEMD_IDLE = 2'b01,
    PEMD_EVAL = 2'b10
  } pemd_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pemd_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } pemd_apb_rsp_type;

  typedef struct packed {
    logic valid;
    logic walk_first;
    logic walk_second;
    logic bypass;
    logic ad_enable;
    logic exec_enable;
    logic fault;
    logic report;
    logic rsvd_fault;
    logic range_fault;
    logic absent;
    logic [2:0] levels;
    logic [WID_W-1:0] width;
  } pemd_walk_type;

  typedef struct packed {
    pemd_state_type st;
    logic [CAP_W-1:0] cap;
    logic [ENTRY_W-1:0] entry;
    logic [DATA_W-1:0] addr_lo;
    logic [DATA_W-1:0] addr_hi;
    logic ctx_suppress;
    pemd_apb_rsp_type rsp;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic irq;
    pemd_walk_type walk;
  } pemd_regs_type;

endpackage : pemd_pkg

// ===== logic/pemd_decoder.sv
// Process-entry mode decoder: APB slave holding the entry control bits,
// capabilities and a request address, deciding walk mode and faults.
// Assumes an APB master on pclk and page-walk logic reading walk_o.
//
// Operation
// R1 - Bit 9 enables second-level accessed/dirty updates
// R2 - Bit 9 reserved without second-level or A/D
// R3 - First-level-only and pass-through ignore second-level fields
// R4 - Bits 8:6 type; 000 reserved, 001 first-level
// R5 - Type 010 walks second-level structures only
// R6 - Type 011 walks nested first and second level
// R7 - Type 100 bypasses translation as pass-through
// R8 - Type reserved when its capability is absent
// R9 - Bit 5 enables execute control in second-level
// R10 - Bit 5 reserved without second-level support
// R11 - Width 001/010/011 gives 39/48/57 bits
// R12 - Width 000 reserved with second-level; 1xx reserved
// R13 - Software programs only supported guest widths
// R14 - Address beyond selected width is translation fault
// R15 - Bit 1 suppresses fault recording and reporting
// R16 - Context-level suppression overrides this entry's bit
// R17 - Suppression evaluated even when entry absent
// R18 - Bit 0 presence; absent ignores other fields
// R19 - Reserved encodings raise a suppressible translation fault
`timescale 1ns/1ps
`default_nettype none

module pemd_decoder
  import pemd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire pemd_apb_req_type apb_req,
  output var pemd_apb_rsp_type apb_rsp,
  // Decode result towards the page walker and fault recorder.
  output var pemd_walk_type walk_o,
  // Interrupt.
  output var logic irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pemd_regs_type r;
  pemd_regs_type n;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // All bus handling and the decode itself live here; the decode runs
  // one cycle after the command write so it sees settled registers.
  always_comb
  begin
    logic acc;
    logic [FIELD_W-1:0] tt;
    logic [FIELD_W-1:0] wsel;
    logic present;
    logic suppress;
    logic tt_ok;
    logic uses_sl;
    logic wsel_rsvd;
    logic ad_rsvd;
    logic exec_rsvd;
    logic [WID_W-1:0] width;
    logic [2:0] levels;
    logic [63:0] full_addr;
    logic [EV_W-1:0] set_ev;
    logic [EV_W-1:0] clr_ev;
    pemd_walk_type w;
    acc = 1'b0;
    tt = TT_RSVD;
    wsel = WSEL_NONE;
    present = 1'b0;
    suppress = 1'b0;
    tt_ok = 1'b0;
    uses_sl = 1'b0;
    wsel_rsvd = 1'b0;
    ad_rsvd = 1'b0;
    exec_rsvd = 1'b0;
    width = '0;
    levels = '0;
    full_addr = '0;
    set_ev = '0;
    clr_ev = '0;
    w = '0;
    n = r;

    // Field extraction.
    tt = r.entry[EB_TT_LSB +: FIELD_W]; // [R4]
    wsel = r.entry[EB_WSEL_LSB +: FIELD_W];
    present = r.entry[EB_PRESENT]; // [R18]
    full_addr = {r.addr_hi, r.addr_lo};
    // Either level asking for silence wins, and the bit is read even for
    // an absent entry, so absent-entry faults can be silenced too.
    suppress = r.ctx_suppress | r.entry[EB_SUPPRESS]; // [R15] [R16] [R17]

    // Type against capability; unlisted codes stay reserved.
    case (tt) // [R4] [R8]
      TT_FIRST: tt_ok = r.cap[CB_FIRST];
      TT_SECOND: tt_ok = r.cap[CB_SECOND];
      TT_NESTED: tt_ok = r.cap[CB_NESTED];
      TT_PASS: tt_ok = r.cap[CB_PASS];
      default: tt_ok = 1'b0;
    endcase
    // Only types 010 and 011 use the width and the second-level enables.
    uses_sl = (tt == TT_SECOND) || (tt == TT_NESTED); // [R3] [R5] [R6]

    // Width selection for the second-level walk.
    case (wsel) // [R11]
      WSEL_39:
      begin
        width = WIDTH_39;
        levels = LEVELS_39;
      end
      WSEL_48:
      begin
        width = WIDTH_48;
        levels = LEVELS_48;
      end
      WSEL_57:
      begin
        width = WIDTH_57;
        levels = LEVELS_57;
      end
      default:
      begin
        width = '0;
        levels = '0;
      end
    endcase
    wsel_rsvd = uses_sl && (((wsel == WSEL_NONE) && r.cap[CB_SECOND]) || (wsel > WSEL_57)); // [R12] [R3]

    // Reserved-zero checks come before the ignore rule for other types.
    ad_rsvd = r.entry[EB_SL_AD] && !(r.cap[CB_SECOND] && r.cap[CB_SLAD]); // [R2]
    exec_rsvd = r.entry[EB_SL_EXEC] && !r.cap[CB_SECOND]; // [R10]

    // Result assembly.
    w.absent = !present; // [R18]
    w.rsvd_fault = present && (!tt_ok || wsel_rsvd || ad_rsvd || exec_rsvd); // [R19]
    w.range_fault = present && tt_ok && uses_sl && !wsel_rsvd && (width != '0) &&
                    ((full_addr >> width) != 64'h0); // [R14]
    w.fault = w.absent || w.rsvd_fault || w.range_fault;
    w.report = w.fault && !suppress; // [R15]
    if (!w.fault)
    begin
      w.walk_first = (tt == TT_FIRST) || (tt == TT_NESTED); // [R4] [R6]
      w.walk_second = uses_sl; // [R5] [R6]
      w.bypass = (tt == TT_PASS); // [R7]
      w.ad_enable = uses_sl && r.entry[EB_SL_AD]; // [R1] [R3]
      w.exec_enable = uses_sl && r.entry[EB_SL_EXEC]; // [R9] [R3]
      w.levels = uses_sl ? levels : 3'h0;
      w.width = uses_sl ? width : 7'h00;
    end

    // Decode sequencing; result flags other than valid and report hold.
    n.walk.valid = 1'b0;
    n.walk.report = 1'b0;
    case (r.st)
      PEMD_EVAL:
      begin
        n.walk = w;
        n.walk.valid = 1'b1;
        n.st = PEMD_IDLE;
        set_ev[SB_DONE] = 1'b1;
        set_ev[SB_REPORT] = w.report;
        set_ev[SB_SILENT] = w.fault && suppress;
      end
      default:
      begin
        n.st = PEMD_IDLE;
      end
    endcase

    // APB slave: one wait state, then the access completes.
    acc = apb_req.psel && apb_req.penable && r.rsp.pready;
    n.rsp.pready = apb_req.psel && apb_req.penable && !r.rsp.pready;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = '0;
    if (n.rsp.pready)
    begin
      if (apb_req.paddr == OFS_CAP)
        n.rsp.prdata[CAP_W-1:0] = r.cap;
      else if (apb_req.paddr == OFS_ENTRY)
        n.rsp.prdata[ENTRY_W-1:0] = r.entry;
      else if (apb_req.paddr == OFS_ADDR_LO)
        n.rsp.prdata = r.addr_lo;
      else if (apb_req.paddr == OFS_ADDR_HI)
        n.rsp.prdata = r.addr_hi;
      else if (apb_req.paddr == OFS_CMD)
        n.rsp.prdata[CMDB_CTX] = r.ctx_suppress;
      else if (apb_req.paddr == OFS_RESULT)
      begin
        n.rsp.prdata[10:0] = {r.walk.absent, r.walk.range_fault, r.walk.rsvd_fault,
                              r.walk.report, r.walk.fault, r.walk.exec_enable,
                              r.walk.ad_enable, r.walk.bypass, r.walk.walk_second,
                              r.walk.walk_first, (r.st == PEMD_EVAL)};
        n.rsp.prdata[RB_LEVELS_LSB +: 3] = r.walk.levels;
        n.rsp.prdata[RB_WIDTH_LSB +: WID_W] = r.walk.width;
      end
      else if (apb_req.paddr == OFS_STATUS)
        n.rsp.prdata[EV_W-1:0] = r.status;
      else if (apb_req.paddr == OFS_MASK)
        n.rsp.prdata[EV_W-1:0] = r.mask;
      else
        n.rsp.pslverr = 1'b1;
    end

    // Writes take effect only at the completing edge.
    if (acc && apb_req.pwrite)
    begin
      if (apb_req.paddr == OFS_CAP)
        n.cap = apb_req.pwdata[CAP_W-1:0];
      else if (apb_req.paddr == OFS_ENTRY)
        n.entry = apb_req.pwdata[ENTRY_W-1:0];
      else if (apb_req.paddr == OFS_ADDR_LO)
        n.addr_lo = apb_req.pwdata;
      else if (apb_req.paddr == OFS_ADDR_HI)
        n.addr_hi = apb_req.pwdata;
      else if (apb_req.paddr == OFS_CMD)
      begin
        n.ctx_suppress = apb_req.pwdata[CMDB_CTX]; // [R16]
        if (apb_req.pwdata[CMDB_GO])
          n.st = PEMD_EVAL;
      end
      else if (apb_req.paddr == OFS_STATUS)
        clr_ev = apb_req.pwdata[EV_W-1:0];
      else if (apb_req.paddr == OFS_MASK)
        n.mask = apb_req.pwdata[EV_W-1:0];
    end

    // A new event beats a clear written in the same cycle.
    n.status = (r.status & ~clr_ev) | set_ev;
    n.irq = |(n.status & n.mask);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Every field returns to a constant under reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= PEMD_IDLE;
      r.cap <= CAP_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs come straight from the registers.
  assign apb_rsp = r.rsp;
  assign walk_o = r.walk;
  assign irq = r.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence go_write;
    apb_req.psel && apb_req.penable && r.rsp.pready && apb_req.pwrite &&
    (apb_req.paddr == OFS_CMD) && apb_req.pwdata[CMDB_GO];
  endsequence

  sequence eval_then_result;
    (r.st == PEMD_EVAL) ##1 (walk_o.valid && (r.st == PEMD_IDLE));
  endsequence

  chk_go_gives_result: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    go_write |=> eval_then_result)
    else $error("command write did not produce a result two cycles later");

  chk_bypass_clean: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.bypass |->
      !walk_o.walk_first && !walk_o.walk_second && !walk_o.ad_enable && !walk_o.exec_enable)
    else $error("pass-through result carries translation settings");

  chk_absent_fault: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.absent |->
      walk_o.fault && !walk_o.bypass && !walk_o.walk_first && !walk_o.walk_second)
    else $error("absent entry did not fault cleanly");

  chk_report_gate: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid |->
      (walk_o.report == (walk_o.fault && !($past(r.ctx_suppress) || $past(r.entry[EB_SUPPRESS])))))
    else $error("fault report does not follow suppression");

  chk_range_width: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.range_fault |-> walk_o.fault && !walk_o.walk_second)
    else $error("range fault without fault or with a walk");

  chk_width_levels: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.walk_second |->
      ((walk_o.width == WIDTH_39) && (walk_o.levels == LEVELS_39)) ||
      ((walk_o.width == WIDTH_48) && (walk_o.levels == LEVELS_48)) ||
      ((walk_o.width == WIDTH_57) && (walk_o.levels == LEVELS_57)))
    else $error("second-level walk width and levels mismatch");

  chk_ad_reserved: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && $past(r.entry[EB_SL_AD]) && $past(r.entry[EB_PRESENT]) &&
      !($past(r.cap[CB_SECOND]) && $past(r.cap[CB_SLAD])) |-> walk_o.rsvd_fault)
    else $error("reserved access/dirty enable not faulted");

  chk_report_sticky: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    walk_o.report |=> r.status[SB_REPORT] && r.status[SB_DONE])
    else $error("reported fault did not set status");

  chk_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == |(r.status & r.mask))
    else $error("interrupt differs from masked status");

  chk_apb_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("apb access not answered after one wait state");

  chk_sl_fields_idle: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && !walk_o.walk_second |->
      !walk_o.ad_enable && !walk_o.exec_enable && (walk_o.width == '0) && (walk_o.levels == '0))
    else $error("second-level settings present without a second-level walk");

  chk_ad_follows: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.walk_second |-> (walk_o.ad_enable == $past(r.entry[EB_SL_AD])))
    else $error("access/dirty enable does not follow the entry bit");

  chk_exec_follows: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.walk_second |-> (walk_o.exec_enable == $past(r.entry[EB_SL_EXEC])))
    else $error("execute enable does not follow the entry bit");

  chk_type_reserved: assert property ( // [R4] [R19]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && $past(r.entry[EB_PRESENT]) &&
      ($past(r.entry[EB_TT_LSB +: FIELD_W]) == TT_RSVD) |-> walk_o.rsvd_fault && walk_o.fault)
    else $error("reserved translation type not faulted");

  chk_pass_capability: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && $past(r.entry[EB_PRESENT]) && !$past(r.cap[CB_PASS]) &&
      ($past(r.entry[EB_TT_LSB +: FIELD_W]) == TT_PASS) |-> walk_o.rsvd_fault && !walk_o.bypass)
    else $error("pass-through without capability not faulted");

  chk_width_reserved: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && $past(r.entry[EB_PRESENT]) &&
      ($past(r.entry[EB_TT_LSB +: FIELD_W]) == TT_SECOND) &&
      ($past(r.entry[EB_WSEL_LSB +: FIELD_W]) > WSEL_57) |-> walk_o.rsvd_fault)
    else $error("reserved address width not faulted");

  chk_silent_sticky: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    walk_o.valid && walk_o.fault && !walk_o.report |-> r.status[SB_SILENT])
    else $error("suppressed fault did not set its status bit");

endmodule : pemd_decoder

`default_nettype wire

// ===== tb/pemd_walk_sink.sv
// Result sink standing in for the page walker and fault recorder.
// Assumes walk_i comes straight from the decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pemd_walk_sink
  import pemd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Decode results.
  input wire pemd_walk_type walk_i,
  // Tallies.
  output var logic [15:0] results_r,
  output var logic [15:0] reports_r
);
  // ---------------------------------------------------------------
  // Tally
  // ---------------------------------------------------------------
  // Counting pulses catches a result that is lost or doubled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      results_r <= 16'h0;
      reports_r <= 16'h0;
    end
    else if (walk_i.valid)
    begin
      results_r <= results_r + 16'h1;
      reports_r <= reports_r + {15'h0, walk_i.report};
    end
  end
endmodule : pemd_walk_sink

`default_nettype wire

// ===== tb/test_pasid_entry_mode_decoder.sv
// Self-checking bench for the process-entry mode decoder.
// Assumes the package, decoder and result sink are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_pasid_entry_mode_decoder
  import pemd_pkg::*;
  ;
  logic pclk;
  logic presetn;
  pemd_apb_req_type req;
  pemd_apb_rsp_type rsp;
  pemd_walk_type walk;
  logic irq;
  logic [15:0] n_res;
  logic [15:0] n_rep;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_dec = 0;
  int n_rpt = 0;

  pemd_decoder DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .walk_o(walk), .irq(irq));
  pemd_walk_sink sink (.pclk(pclk), .presetn(presetn), .walk_i(walk),
    .results_r(n_res), .reports_r(n_rep));

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  // Free-running 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ---------------------------------------------------------------
  // Bus and decode helpers
  // ---------------------------------------------------------------
  // The request is held until pready is seen at a rising edge, for at most 16 edges.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic e, output logic [DATA_W-1:0] q);
    int i;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (rsp.pready === 1'b1)
        break;
    end
    q = rsp.prdata;
    chk({30'h0, rsp.pready, rsp.pslverr}, {30'h0, 1'b1, e});
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    apb(1'b1, a, d, 1'b0, q);
  endtask : wr

  function automatic logic [11:0] ent(input logic [2:0] t, input logic [2:0] w);
    return {3'h0, t, 1'b0, w, 2'b01};
  endfunction : ent

  function automatic logic [WID_W-1:0] wid(input logic [2:0] lv);
    case (lv)
      LEVELS_39: return WIDTH_39;
      LEVELS_48: return WIDTH_48;
      LEVELS_57: return WIDTH_57;
      default: return 7'h0;
    endcase
  endfunction : wid

  // Flags: first,second,bypass,ad,exec,fault,report,rsvd,range,absent.
  task automatic decode(input logic [10:0] cap, input logic [11:0] e, input logic [31:0] hi,
    input int ctx, input logic [9:0] ef, input logic [2:0] lv);
    int i;
    wr(OFS_CAP, {21'h0, cap}); // Width mask lists every defined width except where cap is 11'h0.
    wr(OFS_ENTRY, {20'h0, e});
    wr(OFS_ADDR_HI, hi);
    wr(OFS_CMD, {30'h0, ctx[0], 1'b1});
    for (i = 0; i < 8 && walk.valid !== 1'b1; i++)
    begin
      @(posedge pclk);
      #1;
    end
    n_dec++;
    n_rpt += ef[3];
    chk({walk.walk_first, walk.walk_second, walk.bypass, walk.ad_enable, walk.exec_enable,
      walk.fault, walk.report, walk.rsvd_fault, walk.range_fault, walk.absent}, ef);
    chk({walk.levels, walk.width}, {lv, wid(lv)});
  endtask : decode

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [DATA_W-1:0] q;
    apb(1'b0, OFS_CAP, 32'h0, 1'b0, q);
    chk(q, {21'h0, CAP_RST});
    wr(OFS_ADDR_LO, 32'h00000fff);
    apb(1'b0, OFS_ADDR_LO, 32'h0, 1'b0, q);
    chk(q, 32'h00000fff);
    apb(1'b1, 8'h20, 32'h1, 1'b1, q);
    apb(1'b0, 8'h20, 32'h0, 1'b1, q);
    chk(q, 32'h0);
  endtask : t_regs

  task automatic t_types();
    logic [9:0] ef [8] = '{10'h01c, 10'h200, 10'h100, 10'h300, 10'h080, 10'h01c, 10'h01c,
      10'h01c};
    for (int t = 0; t < 8; t++)
      decode(CAP_RST, ent(t[2:0], WSEL_39), 0, 0, ef[t], (t == 2 || t == 3) ? LEVELS_39 : 3'h0);
    for (int t = 1; t < 5; t++)
      decode(11'h0, ent(t[2:0], WSEL_39), 0, 0, 10'h01c, 3'h0);
  endtask : t_types

  task automatic t_widths();
    logic [2:0] lv [8] = '{3'h0, LEVELS_39, LEVELS_48, LEVELS_57, 3'h0, 3'h0, 3'h0, 3'h0};
    for (int w = 0; w < 8; w++)
      decode(CAP_RST, ent(TT_SECOND, w[2:0]), 0, 0, (lv[w] == 3'h0) ? 10'h01c : 10'h100, lv[w]);
    decode(CAP_RST, ent(TT_NESTED, WSEL_39), 32'h80, 0, 10'h01a, 3'h0);
    decode(CAP_RST, ent(TT_SECOND, WSEL_39), 32'h7f, 0, 10'h100, LEVELS_39);
    decode(CAP_RST, ent(TT_SECOND, WSEL_48), 32'h10000, 0, 10'h01a, 3'h0);
    decode(CAP_RST, ent(TT_NESTED, WSEL_57), 32'h1ffffff, 0, 10'h300, LEVELS_57);
    decode(CAP_RST, ent(TT_SECOND, WSEL_57), 32'h2000000, 0, 10'h01a, 3'h0);
  endtask : t_widths

  task automatic t_enables();
    decode(CAP_RST, ent(TT_SECOND, WSEL_48) | 12'h220, 0, 0, 10'h160, LEVELS_48);
    decode(CAP_RST, ent(TT_NESTED, WSEL_48), 0, 0, 10'h300, LEVELS_48);
    decode(11'h70f, ent(TT_SECOND, WSEL_48) | 12'h200, 0, 0, 10'h01c, 3'h0);
    decode(11'h71d, ent(TT_FIRST, WSEL_39) | 12'h020, 0, 0, 10'h01c, 3'h0);
    decode(11'h71d, ent(TT_FIRST, WSEL_NONE), 0, 0, 10'h200, 3'h0);
    decode(CAP_RST, ent(TT_PASS, 3'h7), 32'hffffffff, 0, 10'h080, 3'h0);
  endtask : t_enables

  task automatic t_suppress();
    decode(CAP_RST, 12'h3fc, 0, 0, 10'h019, 3'h0);
    decode(CAP_RST, 12'h3fe, 0, 0, 10'h011, 3'h0);
    decode(CAP_RST, 12'h3fc, 0, 1, 10'h011, 3'h0);
    decode(CAP_RST, ent(TT_RSVD, WSEL_39) | 12'h002, 0, 0, 10'h014, 3'h0);
  endtask : t_suppress

  // Masked event stays quiet; unmasking raises irq; clearing drops it.
  task automatic t_irq();
    logic [DATA_W-1:0] q;
    wr(OFS_STATUS, 32'h7);
    wr(OFS_MASK, 32'h0);
    decode(CAP_RST, 12'h0, 0, 0, 10'h019, 3'h0);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, q);
    chk(q, 32'h3);
    apb(1'b0, OFS_RESULT, 32'h0, 1'b0, q);
    chk(q, 32'h440);
    wr(OFS_MASK, 32'h2);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h2);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, q);
    chk(q, 32'h1);
  endtask : t_irq

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    req = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_types();
    t_widths();
    t_enables();
    t_suppress();
    t_irq();
    chk({16'h0, n_res}, n_dec);
    chk({16'h0, n_rep}, n_rpt);
    wrap_up();
  end
endmodule : test_pasid_entry_mode_decoder

`default_nettype wire
